// ===== rtl/kmst_scanner.sv
`timescale 1ns/1ps
module kmst_scanner #(
	parameter int ROWS  = kmst_pkg::MATRIX_ROWS,
	parameter int COLS  = kmst_pkg::MATRIX_COLS,
	parameter int DEPTH = kmst_pkg::SCRATCH_DEPTH
) (
	input  wire logic       CLK,
	input  wire logic       RESETN,
	input  wire logic [7:0] IO_ADDR_LO,
	input  wire logic [7:0] IO_ADDR_HI,
	input  wire logic       IO_RD,
	input  wire logic       IO_WR,
	output logic      [7:0] IO_RDATA,
	output logic            IO_RDATA_VALID,
	input  wire logic [7:0] MATRIX_COL_N,
	output logic      [7:0] MATRIX_ROW_SEL,
	input  wire logic       SHIFT_KEY,
	input  wire logic       CTRL_KEY,
	input  wire logic       ALPHA_LOCK_KEY,
	input  wire logic [5:0] KEY_POS,
	input  wire logic       KEY_POS_VALID,
	output logic      [8:0] TABLE_INDEX,
	output logic      [7:0] RAW_KEY_CODE,
	output logic            RAW_KEY_VALID,
	output logic      [1:0] FN_TABLE_USE,
	input  wire logic [1:0] FN_KEY_TABLE_SELECT,
	input  wire logic       FN_KEY_TABLE_SELECT_WE,
	output logic      [15:0] TABLE_POINTER_ADDR,
	input  wire logic [7:0] BACKGROUND_ATTRIBUTE_FLAG,
	input  wire logic       BACKGROUND_ATTRIBUTE_WE,
	output logic            ATTR_REVERSE,
	output logic            ATTR_FULL,
	output logic            ATTR_UNDERLINE,
	output logic            ATTR_BLINK,
	input  wire logic [3:0] PROG_KEY_ID,
	input  wire logic [7:0] PROG_KEY_BYTE,
	input  wire logic       PROG_KEY_START,
	input  wire logic       PROG_KEY_WE,
	output logic            PROG_KEY_ERROR,
	output logic      [7:0] PROG_KEY_FILL,
	input  wire logic       TAB_PRESS,
	output logic      [6:0] CURSOR_POSITION_PTR
);
	import kmst_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [7:0] col_sync;
	logic [2:0] mod_sync;

	kmst_sync2 #(.WIDTH(8), .INIT(COLUMN_IDLE)) u_col_sync (
		.CLK    (CLK),
		.RESETN (RESETN),
		.d      (MATRIX_COL_N),
		.q      (col_sync)
	);

	kmst_sync2 #(.WIDTH(3), .INIT(3'b000)) u_mod_sync (
		.CLK    (CLK),
		.RESETN (RESETN),
		.d      ({ALPHA_LOCK_KEY, CTRL_KEY, SHIFT_KEY}),
		.q      (mod_sync)
	);

	// ----------------------------------------------------------------
	// Port decode and row drive
	// ----------------------------------------------------------------
	logic port_hit;
	logic [7:0] prev_col_reg;
	logic [7:0] prev_row_reg;
	logic       have_prev_reg;

	// Only reads decode; a write to the port gives no answer but still loads the row latch below
	always_comb begin
		port_hit = IO_RD && (IO_ADDR_LO == KEY_MATRIX_COLUMN_PORT_ADDR);
	end

	// Row pattern is the accumulator on the upper address byte
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			MATRIX_ROW_SEL <= 8'h00;
		end else if (IO_ADDR_LO == KEY_MATRIX_COLUMN_PORT_ADDR) begin
			MATRIX_ROW_SEL <= IO_ADDR_HI;
		end
	end

	// ----------------------------------------------------------------
	// Column read with two-scan confirmation
	// ----------------------------------------------------------------
	// A closure is returned only if the previous read of the same row
	// saw it too; bounce therefore costs one extra poll, not a ghost key.
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			IO_RDATA       <= COLUMN_IDLE;
			IO_RDATA_VALID <= 1'b0;
			prev_col_reg   <= COLUMN_IDLE;
			prev_row_reg   <= 8'h00;
			have_prev_reg  <= 1'b0;
		end else begin
			IO_RDATA_VALID <= port_hit;
			if (port_hit) begin
				prev_col_reg  <= col_sync;
				prev_row_reg  <= IO_ADDR_HI;
				have_prev_reg <= 1'b1;
				if (have_prev_reg && prev_row_reg == IO_ADDR_HI) begin
					IO_RDATA <= col_sync | prev_col_reg;
				end else begin
					IO_RDATA <= COLUMN_IDLE;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Modifier selection
	// ----------------------------------------------------------------
	kmst_mod_t mod_state;

	always_comb begin
		if (mod_sync[1] && mod_sync[0]) begin
			mod_state = KMST_MOD_CTRL_SHIFT;
		end else if (mod_sync[1]) begin
			mod_state = KMST_MOD_CTRL;
		end else if (mod_sync[0]) begin
			mod_state = KMST_MOD_SHIFT;
		end else begin
			mod_state = KMST_MOD_NONE;
		end
	end

	// ----------------------------------------------------------------
	// Translation table index
	// ----------------------------------------------------------------
	logic       is_letter;
	logic       is_digit;
	logic       is_arrow;
	logic [3:0] prog_num;
	logic [8:0] table_base;
	logic [1:0] fn_sel_reg;

	// Letters occupy 10h-27h except the comma slot at 27h
	always_comb begin
		is_letter = (KEY_POS >= 6'h10) && (KEY_POS <= 6'h26);
		is_digit  = (KEY_POS >= 6'h08 && KEY_POS <= 6'h0F)
		         || KEY_POS == 6'h2E || KEY_POS == 6'h2F;
		is_arrow  = KEY_POS == 6'h28 || KEY_POS == 6'h29
		         || KEY_POS == 6'h30 || KEY_POS == 6'h31;
		if (KEY_POS >= 6'h08 && KEY_POS <= 6'h0F) begin
			prog_num = 4'(KEY_POS - 6'h07);
		end else if (KEY_POS == 6'h2F) begin
			prog_num = 4'd9;
		end else if (KEY_POS == 6'h2E) begin
			prog_num = 4'd0;
		end else if (KEY_POS == 6'h28) begin
			prog_num = 4'd10;
		end else if (KEY_POS == 6'h29) begin
			prog_num = 4'd13;
		end else if (KEY_POS == 6'h30) begin
			prog_num = 4'd11;
		end else begin
			prog_num = 4'd12;
		end
	end

	// Shift and control outrank the lock; lock only touches letters
	always_comb begin
		case (mod_state)
			KMST_MOD_CTRL_SHIFT: table_base = CTRL_SHIFT_OFF;
			KMST_MOD_CTRL:       table_base = CONTROL_TABLE_OFF;
			KMST_MOD_SHIFT:      table_base = SHIFT_TABLE_OFF;
			default: begin
				if (mod_sync[2] && is_letter) begin
					table_base = CAPS_TABLE_OFF;
				end else begin
					table_base = BASE_TABLE_OFF;
				end
			end
		endcase
	end

	// Index and raw code registered per key event
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			TABLE_INDEX   <= BASE_TABLE_OFF;
			RAW_KEY_CODE  <= CODE_IGNORED;
			RAW_KEY_VALID <= 1'b0;
		end else begin
			RAW_KEY_VALID <= 1'b0;
			if (KEY_POS_VALID) begin
				TABLE_INDEX <= table_base + {3'b000, KEY_POS};
				if (fn_sel_reg == FN_MODE_RAW && (is_digit || is_arrow)) begin
					RAW_KEY_VALID <= 1'b1;
					if (is_arrow) begin
						RAW_KEY_CODE <= RAW_ARROW_BASE + {4'h0, prog_num - 4'd10};
					end else begin
						RAW_KEY_CODE <= RAW_FKEY_BASE + {4'h0, prog_num};
					end
				end else if (mod_state == KMST_MOD_CTRL && KEY_POS == 6'h29) begin
					RAW_KEY_CODE <= CTRL_BACKARROW_CODE;
				end else if (mod_state == KMST_MOD_CTRL && is_digit && prog_num != 4'd0) begin
					RAW_KEY_CODE <= CTRL_DIGIT_BASE + {4'h0, prog_num - 4'd1};
				end else begin
					RAW_KEY_CODE <= CODE_IGNORED;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Function key mode and table pointer area
	// ----------------------------------------------------------------
	// Value 3 is undefined and refused; old mode stays
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			fn_sel_reg <= FN_MODE_BUILTIN;
		end else if (FN_KEY_TABLE_SELECT_WE && FN_KEY_TABLE_SELECT != 2'd3) begin
			fn_sel_reg <= FN_KEY_TABLE_SELECT;
		end
	end

	always_comb begin
		FN_TABLE_USE       = fn_sel_reg;
		TABLE_POINTER_ADDR = TABLE_POINTER_BASE;
	end

	// ----------------------------------------------------------------
	// Background attribute flag
	// ----------------------------------------------------------------
	logic [7:0] attr_reg;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			attr_reg <= ATTR_RESET;
		end else if (BACKGROUND_ATTRIBUTE_WE) begin
			attr_reg <= BACKGROUND_ATTRIBUTE_FLAG;
		end
	end

	always_comb begin
		ATTR_REVERSE   = attr_reg[ATTR_REVERSE_BIT];
		ATTR_FULL      = attr_reg[ATTR_FULL_BIT];
		ATTR_UNDERLINE = attr_reg[ATTR_UNDERLINE_BIT];
		ATTR_BLINK     = attr_reg[ATTR_BLINK_BIT];
	end

	// ----------------------------------------------------------------
	// Programmable key scratchpad
	// ----------------------------------------------------------------
	// Packed back to back: length byte then that many bytes. Keys must
	// be written in order; rewriting one appends a new copy at the write pointer and keeps the rest.
	logic [7:0] scratch_mem [DEPTH];
	logic [7:0] wr_ptr_reg;
	logic [7:0] len_ptr_reg;
	logic [7:0] len_reg;
	logic       def_open_reg;
	logic       def_ok;
	logic       byte_ok;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			wr_ptr_reg     <= 8'h00;
			len_ptr_reg    <= 8'h00;
			len_reg        <= 8'h00;
			def_open_reg   <= 1'b0;
			PROG_KEY_ERROR <= 1'b0;
			PROG_KEY_FILL  <= 8'h00;
		end else begin
			PROG_KEY_ERROR <= 1'b0;
			if (PROG_KEY_START) begin
				if (32'(PROG_KEY_ID) >= PROG_KEY_COUNT || wr_ptr_reg == 8'hFF) begin
					PROG_KEY_ERROR <= 1'b1;
					def_open_reg   <= 1'b0;
				end else begin
					len_ptr_reg  <= wr_ptr_reg;
					wr_ptr_reg   <= wr_ptr_reg + 8'd1;
					len_reg      <= 8'h00;
					def_open_reg <= 1'b1;
				end
			end else if (PROG_KEY_WE && def_open_reg) begin
				if (len_reg >= PROG_KEY_MAX_LEN || wr_ptr_reg == 8'hFF) begin
					PROG_KEY_ERROR <= 1'b1;
				end else begin
					len_reg    <= len_reg + 8'd1;
					wr_ptr_reg <= wr_ptr_reg + 8'd1;
				end
			end
			PROG_KEY_FILL <= wr_ptr_reg;
		end
	end

	// Storage has no reset; length slot rewritten on every byte
	always_ff @(posedge CLK) begin
		if (PROG_KEY_START && def_ok) begin
			scratch_mem[wr_ptr_reg] <= 8'h00;
		end else if (PROG_KEY_WE && def_open_reg && byte_ok) begin
			scratch_mem[wr_ptr_reg]  <= PROG_KEY_BYTE;
			scratch_mem[len_ptr_reg] <= len_reg + 8'd1;
		end
	end

	always_comb begin
		def_ok  = 32'(PROG_KEY_ID) < PROG_KEY_COUNT && wr_ptr_reg != 8'hFF;
		byte_ok = len_reg < PROG_KEY_MAX_LEN && wr_ptr_reg != 8'hFF;
	end

	// ----------------------------------------------------------------
	// Tab stop cursor
	// ----------------------------------------------------------------
	logic [6:0] tab_next;

	always_comb begin
		tab_next = CURSOR_POSITION_PTR + TAB_STEP - (CURSOR_POSITION_PTR % TAB_STEP);
	end

	// Cursor stops at the last column rather than wrapping
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			CURSOR_POSITION_PTR <= 7'd0;
		end else if (TAB_PRESS) begin
			if (tab_next > LINE_LAST_COL) begin
				CURSOR_POSITION_PTR <= LINE_LAST_COL;
			end else begin
				CURSOR_POSITION_PTR <= tab_next;
			end
		end
	end

endmodule

// ===== include/kmst_pkg.sv
package kmst_pkg;

	// ----------------------------------------------------------------
	// Port map and matrix geometry
	// ----------------------------------------------------------------
	localparam logic [7:0]  KEY_MATRIX_COLUMN_PORT_ADDR = 8'h0E;
	localparam int          MATRIX_ROWS                 = 8;
	localparam int          MATRIX_COLS                 = 8;
	localparam logic [7:0]  COLUMN_IDLE                 = 8'hFF;

	// ----------------------------------------------------------------
	// Translation table layout
	// ----------------------------------------------------------------
	localparam logic [15:0] TABLE_POINTER_BASE  = 16'h2000;
	localparam logic [8:0]  BASE_TABLE_OFF      = 9'h000;
	localparam logic [8:0]  SHIFT_TABLE_OFF     = 9'h040;
	localparam logic [8:0]  CONTROL_TABLE_OFF   = 9'h080;
	localparam logic [8:0]  CAPS_TABLE_OFF      = 9'h0C0;
	localparam logic [8:0]  CTRL_SHIFT_OFF      = 9'h100;
	localparam logic [7:0]  CODE_IGNORED        = 8'h00;
	localparam logic [7:0]  RAW_FKEY_BASE       = 8'h80;
	localparam logic [7:0]  RAW_ARROW_BASE      = 8'h8A;
	localparam logic [7:0]  CTRL_BACKARROW_CODE = 8'h7F;
	localparam logic [7:0]  CTRL_DIGIT_BASE     = 8'h81;

	// ----------------------------------------------------------------
	// Function key mode, attributes, programmable keys, tabs
	// ----------------------------------------------------------------
	localparam logic [1:0]  FN_MODE_BUILTIN   = 2'd0;
	localparam logic [1:0]  FN_MODE_APP       = 2'd1;
	localparam logic [1:0]  FN_MODE_RAW       = 2'd2;
	localparam int          ATTR_REVERSE_BIT  = 7;
	localparam int          ATTR_FULL_BIT     = 6;
	localparam int          ATTR_UNDERLINE_BIT = 5;
	localparam int          ATTR_BLINK_BIT    = 4;
	localparam logic [7:0]  ATTR_RESET        = 8'h00;
	localparam int          PROG_KEY_COUNT    = 14;
	localparam logic [7:0]  PROG_KEY_MAX_LEN  = 8'd236;
	localparam logic [6:0]  TAB_STEP          = 7'd5;
	localparam logic [6:0]  LINE_LAST_COL     = 7'd79;
	localparam int          SCRATCH_DEPTH     = 256;

	typedef enum logic [1:0] {
		KMST_MOD_NONE,
		KMST_MOD_SHIFT,
		KMST_MOD_CTRL,
		KMST_MOD_CTRL_SHIFT
	} kmst_mod_t;

endpackage

// ===== rtl/kmst_sync2.sv
`timescale 1ns/1ps
// Two-stage synchroniser bank for asynchronous pin levels
module kmst_sync2 #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	input  wire logic             CLK,
	input  wire logic             RESETN,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	// First stage is read only by the second stage
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			meta_reg <= INIT;
			q        <= INIT;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// ===== testbench/kmst_key_matrix.sv
`timescale 1ns/1ps
// Bare keyswitch matrix, no encoder: a closed key ties its column to its row
module kmst_key_matrix (
	input  wire logic [7:0]  row_sel,
	input  wire logic [63:0] keys_closed,
	output logic      [7:0]  col_n
);
	// Pull-ups hold open columns high; only selected rows can pull one low
	always_comb begin
		col_n = 8'hFF;
		for (int r = 0; r < 8; r++) begin
			for (int c = 0; c < 8; c++) begin
				if (row_sel[r] && keys_closed[r*8+c]) begin
					col_n[c] = 1'b0;
				end
			end
		end
	end
endmodule

// ===== testbench/kmst_properties.sv
`timescale 1ns/1ps
module kmst_properties (
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic [7:0]  IO_ADDR_LO,
	input wire logic [7:0]  IO_ADDR_HI,
	input wire logic        IO_RD,
	input wire logic [7:0]  IO_RDATA,
	input wire logic        IO_RDATA_VALID,
	input wire logic [7:0]  MATRIX_COL_N,
	input wire logic [7:0]  MATRIX_ROW_SEL,
	input wire logic        SHIFT_KEY,
	input wire logic        CTRL_KEY,
	input wire logic        ALPHA_LOCK_KEY,
	input wire logic [5:0]  KEY_POS,
	input wire logic        KEY_POS_VALID,
	input wire logic [8:0]  TABLE_INDEX,
	input wire logic [1:0]  FN_TABLE_USE,
	input wire logic [1:0]  FN_KEY_TABLE_SELECT,
	input wire logic        FN_KEY_TABLE_SELECT_WE,
	input wire logic [15:0] TABLE_POINTER_ADDR,
	input wire logic [7:0]  BACKGROUND_ATTRIBUTE_FLAG,
	input wire logic        BACKGROUND_ATTRIBUTE_WE,
	input wire logic        ATTR_REVERSE,
	input wire logic        ATTR_FULL,
	input wire logic        ATTR_UNDERLINE,
	input wire logic        ATTR_BLINK,
	input wire logic [3:0]  PROG_KEY_ID,
	input wire logic        PROG_KEY_START,
	input wire logic        PROG_KEY_ERROR,
	input wire logic        TAB_PRESS,
	input wire logic [6:0]  CURSOR_POSITION_PTR
);
	import kmst_pkg::*;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// ----------------------------------------------------------------
	// Steps of a port read and of a stable modifier state
	// ----------------------------------------------------------------
	sequence port_read;
		IO_RD && IO_ADDR_LO == 8'h0E;
	endsequence
	// Modifiers must settle through the synchronisers before a lookup
	sequence mods_held(logic s, logic c, logic a);
		(SHIFT_KEY == s && CTRL_KEY == c && ALPHA_LOCK_KEY == a) [*4];
	endsequence
	a_read_answered: assert property (port_read |=> IO_RDATA_VALID)
		else $error("port read not answered");
	a_write_no_answer: assert property (IO_RDATA_VALID |-> $past(IO_RD) && $past(IO_ADDR_LO) == 8'h0E)
		else $error("answer without a port read");
	a_data_holds: assert property (!IO_RDATA_VALID |-> $stable(IO_RDATA))
		else $error("column byte moved without a read");
	a_row_latched: assert property (IO_ADDR_LO == 8'h0E |=> MATRIX_ROW_SEL == $past(IO_ADDR_HI))
		else $error("row pattern not driven");
	a_idle_ones: assert property ((MATRIX_COL_N == 8'hFF) [*4] ##0 port_read |=> IO_RDATA == 8'hFF)
		else $error("idle row not all ones");
	a_base_index: assert property (mods_held(0, 0, 0) ##0 KEY_POS_VALID |=> TABLE_INDEX == {3'h0, $past(KEY_POS)})
		else $error("base table index wrong");
	a_shift_index: assert property (mods_held(1, 0, 0) ##0 KEY_POS_VALID |=> TABLE_INDEX == 9'h040 + $past(KEY_POS))
		else $error("shift table index wrong");
	a_ctrl_index: assert property (mods_held(0, 1, 0) ##0 KEY_POS_VALID |=> TABLE_INDEX == 9'h080 + $past(KEY_POS))
		else $error("control table index wrong");
	a_ctrl_shift: assert property (mods_held(1, 1, 0) ##0 KEY_POS_VALID |=> TABLE_INDEX == 9'h100 + $past(KEY_POS))
		else $error("control shift index wrong");
	a_fn_mode: assert property (FN_KEY_TABLE_SELECT_WE && FN_KEY_TABLE_SELECT != 2'h3 |=> FN_TABLE_USE == $past(FN_KEY_TABLE_SELECT))
		else $error("function key mode not taken");
	a_attr_bits: assert property (BACKGROUND_ATTRIBUTE_WE |=> {ATTR_REVERSE, ATTR_FULL, ATTR_UNDERLINE, ATTR_BLINK} == $past(BACKGROUND_ATTRIBUTE_FLAG[7:4]))
		else $error("attribute bits misplaced");
	a_tab_stop: assert property (TAB_PRESS && CURSOR_POSITION_PTR < 7'h4B |=> CURSOR_POSITION_PTR == ($past(CURSOR_POSITION_PTR) / 7'h05 + 7'h01) * 7'h05)
		else $error("tab stop wrong");
	a_prog_id_bad: assert property (PROG_KEY_START && PROG_KEY_ID > 4'hD |=> PROG_KEY_ERROR)
		else $error("bad key number accepted");
	a_table_ptr: assert property (TABLE_POINTER_ADDR == TABLE_POINTER_BASE)
		else $error("table pointer base wrong");
endmodule
bind kmst_scanner kmst_properties i_kmst_properties (.*);

// ===== testbench/kmst_scanner_tb_top.sv
`timescale 1ns/1ps
module kmst_scanner_tb_top;
	import kmst_pkg::*;
	logic        clk, resetn, io_rd, io_wr, rd_valid, shift_k, ctrl_k, lock_k, pos_valid;
	logic        raw_valid, fn_we, bg_we, a_rev, a_full, a_ul, a_blink, pk_start, pk_we, pk_err;
	logic        tab, err_seen;
	logic [7:0]  addr_lo, addr_hi, rdata, col_n, row_sel, raw_code, bg_flag, pk_byte, pk_fill;
	logic [7:0]  first_rd, last_rd;
	logic [5:0]  key_pos;
	logic [8:0]  tbl_idx;
	logic [1:0]  fn_use, fn_sel;
	logic [15:0] tbl_ptr;
	logic [3:0]  pk_id;
	logic [6:0]  cursor;
	logic [63:0] keys;
	int          bad_count, n_compared;
	logic [2:0]  t_mod [7] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h1, 3'h6, 3'h2};
	logic [5:0]  t_pos [7] = '{6'h18, 6'h18, 6'h29, 6'h10, 6'h08, 6'h18, 6'h0F};
	logic [8:0]  t_idx [7] = '{9'h018, 9'h058, 9'h0A9, 9'h0D0, 9'h008, 9'h118, 9'h08F};
	logic [5:0]  r_pos [7] = '{6'h2E, 6'h08, 6'h2F, 6'h28, 6'h30, 6'h31, 6'h29};
	logic [7:0]  r_code [7] = '{8'h80, 8'h81, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D};

	kmst_scanner i_kmst_scanner (
		.CLK(clk), .RESETN(resetn), .IO_ADDR_LO(addr_lo), .IO_ADDR_HI(addr_hi),
		.IO_RD(io_rd), .IO_WR(io_wr), .IO_RDATA(rdata), .IO_RDATA_VALID(rd_valid),
		.MATRIX_COL_N(col_n), .MATRIX_ROW_SEL(row_sel), .SHIFT_KEY(shift_k),
		.CTRL_KEY(ctrl_k), .ALPHA_LOCK_KEY(lock_k), .KEY_POS(key_pos),
		.KEY_POS_VALID(pos_valid), .TABLE_INDEX(tbl_idx), .RAW_KEY_CODE(raw_code),
		.RAW_KEY_VALID(raw_valid), .FN_TABLE_USE(fn_use), .FN_KEY_TABLE_SELECT(fn_sel),
		.FN_KEY_TABLE_SELECT_WE(fn_we), .TABLE_POINTER_ADDR(tbl_ptr),
		.BACKGROUND_ATTRIBUTE_FLAG(bg_flag), .BACKGROUND_ATTRIBUTE_WE(bg_we),
		.ATTR_REVERSE(a_rev), .ATTR_FULL(a_full), .ATTR_UNDERLINE(a_ul),
		.ATTR_BLINK(a_blink), .PROG_KEY_ID(pk_id), .PROG_KEY_BYTE(pk_byte),
		.PROG_KEY_START(pk_start), .PROG_KEY_WE(pk_we), .PROG_KEY_ERROR(pk_err),
		.PROG_KEY_FILL(pk_fill), .TAB_PRESS(tab), .CURSOR_POSITION_PTR(cursor)
	);
	kmst_key_matrix i_kmst_key_matrix (.row_sel(row_sel), .keys_closed(keys), .col_n(col_n));

	// ----------------------------------------------------------------
	// Clock, error catcher, shared tasks
	// ----------------------------------------------------------------
	always #2 clk = ~clk;
	// Error is a one-cycle pulse, so latch it for the later compare
	always @(posedge clk) if (pk_err === 1'b1) err_seen <= 1'b1;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic do_reset;
		resetn = 1'b0;
		tick(16);
		resetn = 1'b1;
	endtask
	// One input cycle on the key port; the answer is a one-cycle valid
	task automatic port_read(output logic [7:0] d);
		int k;
		io_rd = 1'b1;
		tick(1);
		io_rd = 1'b0;
		for (k = 0; k < 4 && rd_valid !== 1'b1; k++) tick(1);
		check(rd_valid, 1'b1);
		d = rdata;
	endtask
	// Row must settle through the synchronisers; first read only primes it
	task automatic scan(input logic [7:0] hi, input logic [7:0] exp);
		addr_hi = hi;
		tick(4);
		port_read(first_rd);
		tick(3);
		port_read(last_rd);
		check(last_rd, exp);
	endtask
	task automatic translate(input logic [2:0] mods, input logic [5:0] pos);
		{shift_k, ctrl_k, lock_k} = mods;
		tick(4);
		key_pos = pos;
		pos_valid = 1'b1;
		tick(1);
		pos_valid = 1'b0;
	endtask
	task automatic prog(input logic [3:0] id, input int n);
		err_seen = 1'b0;
		pk_id = id;
		pk_start = 1'b1;
		tick(1);
		pk_start = 1'b0;
		repeat (n) begin
			pk_we = 1'b1;
			pk_byte = pk_byte + 8'h01;
			tick(1);
		end
		pk_we = 1'b0;
		tick(3);
	endtask
	task automatic print_verdict;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		{io_rd, io_wr, shift_k, ctrl_k, lock_k, pos_valid, fn_we, bg_we, pk_we, tab} = '0;
		{addr_hi, bg_flag, pk_byte, keys, key_pos, fn_sel, pk_id, pk_start, err_seen} = '0;
		addr_lo = 8'h0E;
		do_reset();
		check(rdata, 8'hFF);
		check(tbl_ptr, TABLE_POINTER_BASE);
		scan(8'h08, 8'hFF);
		keys[26] = 1'b1;
		scan(8'h08, 8'hFB);
		check(first_rd, 8'hFF);
		for (int c = 0; c < 8; c++) begin
			keys = 64'h1 << (c * 9);
			scan(8'h01 << c, ~(8'h01 << c));
			check(first_rd, 8'hFF);
		end
		io_wr = 1'b1;
		repeat (3) begin
			tick(1);
			check(rd_valid, 1'b0);
		end
		io_wr = 1'b0;
		check(rdata, last_rd);
		$display("test scan done");
		for (int i = 0; i < 7; i++) begin
			translate(t_mod[i], t_pos[i]);
			check(tbl_idx, t_idx[i]);
			check({raw_valid, raw_code}, {1'b0, (i == 2) ? 8'h7F : (i == 6) ? 8'h88 : 8'h00});
		end
		for (int m = 0; m < 4; m++) begin
			fn_sel = m[1:0];
			fn_we = 1'b1;
			tick(1);
			fn_we = 1'b0;
			check(fn_use, (m < 3) ? m[1:0] : 2'h2);
			tick(1);
		end
		for (int i = 0; i < 7; i++) begin
			translate(3'h0, r_pos[i]);
			check({raw_valid, raw_code}, {1'b1, r_code[i]});
		end
		$display("test translate done");
		for (int v = 0; v < 3; v++) begin
			bg_flag = 8'hA5 << v;
			bg_we = 1'b1;
			tick(1);
			bg_we = 1'b0;
			check({a_rev, a_full, a_ul, a_blink}, bg_flag[7:4]);
			tick(1);
		end
		for (int i = 0; i < 17; i++) begin
			tab = 1'b1;
			tick(1);
			check(cursor, (i < 15) ? 16'(5 * (i + 1)) : 16'h004F);
		end
		tab = 1'b0;
		$display("test attribute and tab done");
		prog(4'hE, 0);
		check(err_seen, 1'b1);
		prog(4'h0, 3);
		check({err_seen, pk_fill}, 9'h004);
		do_reset();
		prog(4'h1, 236);
		check({err_seen, pk_fill}, 9'h0ED);
		do_reset();
		prog(4'h2, 237);
		check(err_seen, 1'b1);
		$display("test programmable keys done");
		print_verdict();
	end
	// Whole run is under a thousand cycles; this limit is far beyond it
	initial begin
		#100000;
		bad_count++;
		print_verdict();
	end
endmodule
